// [hw/wtr_pkg.sv]
package wtr_pkg;

  // Channel-local register offsets.
  localparam logic [7:0] WTR_OFS_CTRL = 8'h08;
  localparam logic [7:0] WTR_OFS_VALUE = 8'h09;

  // Field positions.
  localparam int WTR_ENABLE_BIT = 6;
  localparam int WTR_DIR_BIT = 5;
  localparam int WTR_INDEX_LSB = 0;
  localparam int WTR_PULSE_MSB = 3;

  // Template size and widths.
  localparam int WTR_INDEX_W = 5;
  localparam int WTR_SAMPLE_W = 7;
  localparam int WTR_DEPTH = 19;
  localparam logic [4:0] WTR_LAST_INDEX = 5'h12;

  // Reset values.
  localparam logic [7:0] WTR_CTRL_RST = 8'h00;
  localparam logic [6:0] WTR_VALUE_RST = 7'h00;
  localparam logic [6:0] WTR_SAMPLE_RST = 7'h00;

  typedef enum logic {
    WTR_DIR_WRITE,
    WTR_DIR_READ
  } wtr_dir_e;

  typedef struct packed {
    logic reserved;
    logic enable;
    wtr_dir_e dir;
    logic [4:0] index;
  } wtr_ctrl_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
  } wtr_bus_s;

endpackage

// [hw/wtr_access.sv]
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - Enable, direction, index and sample fields take effect only while the pulse-shape select has its top bit set.
// - The access enable resets to 0 (disabled) and writing 1 enables template access for this channel.
// - Direction 0 writes sample data into the template memory and direction 1 reads it back out.
// - Direction resets to write, so an access without touching it stores data.
// - Bits 6 to 0 of the value register read back the template entry at the index only in enabled read access, else the last value written.
// - The sample value field only changes when software writes a new value.
module wtr_access
  import wtr_pkg::*;
#(
  parameter int DEPTH = WTR_DEPTH,
  parameter int SAMPLE_W = WTR_SAMPLE_W
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [7:0] regRdData,
  // Pulse-shape selection from the shared pulse register.
  input wire logic [3:0] pulseShapeSelect,
  // Transmit side template fetch.
  input wire logic [4:0] txSampleIndex,
  output logic [SAMPLE_W-1:0] txSample,
  // Access state for the transmit shaper.
  output logic accessActive
);

  ////////////////////////////////////////////////////////////////////////////
  wtr_bus_s bus;
  wtr_ctrl_s ctrl_r;
  wtr_ctrl_s ctrl_nxt;
  logic [SAMPLE_W-1:0] value_r;
  logic [SAMPLE_W-1:0] value_nxt;
  logic [DEPTH-1:0][SAMPLE_W-1:0] ramMem_r;
  logic [DEPTH-1:0][SAMPLE_W-1:0] ramMem_nxt;
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;
  logic [SAMPLE_W-1:0] txSample_r;
  logic [SAMPLE_W-1:0] txSample_nxt;
  logic active_r;
  logic active_nxt;
  logic userShape;
  logic accessGate;
  logic indexValid;
  logic ctrlWrite;
  logic valueWrite;
  logic ramStore;
  logic [SAMPLE_W-1:0] ramAtIndex;

  assign bus = '{addr: regAddr, wrData: regWrData, wrStrobe: regWrStrobe, rdStrobe: regRdStrobe};
  assign regRdData = rdData_r;
  assign txSample = txSample_r;
  assign accessActive = active_r;

  ////////////////////////////////////////////////////////////////////////////
  // Decode.
  always_comb begin
    userShape = pulseShapeSelect[WTR_PULSE_MSB];
    indexValid = ctrl_r.index <= WTR_LAST_INDEX;
    ctrlWrite = bus.wrStrobe && (bus.addr == WTR_OFS_CTRL);
    valueWrite = bus.wrStrobe && (bus.addr == WTR_OFS_VALUE);
    // The select and enable gate directly as well, because accessActive lags them by a cycle.
    accessGate = active_r && userShape && ctrl_r.enable;
    // A store happens on the sample write itself, so the value written is the value stored.
    ramStore = valueWrite && accessGate && (ctrl_r.dir == WTR_DIR_WRITE) && indexValid;
    ramAtIndex = indexValid ? ramMem_r[ctrl_r.index] : WTR_SAMPLE_RST;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and value registers.
  always_comb begin
    ctrl_nxt = ctrl_r;
    value_nxt = value_r;
    active_nxt = userShape && ctrl_r.enable;
    if (ctrlWrite) begin
      ctrl_nxt = wtr_ctrl_s'(bus.wrData);
      ctrl_nxt.reserved = 1'b0;
    end
    if (valueWrite) begin
      value_nxt = bus.wrData[SAMPLE_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= wtr_ctrl_s'(WTR_CTRL_RST);
      value_r <= WTR_VALUE_RST;
      active_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      value_r <= value_nxt;
      active_r <= active_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Template memory, one entry per generate step.
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : gEntry
      assign ramMem_nxt[gi] = (ramStore && (ctrl_r.index == 5'(gi))) ?
                              bus.wrData[SAMPLE_W-1:0] : ramMem_r[gi];
    end
  endgenerate

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ramMem_r <= '0;
    end else begin
      ramMem_r <= ramMem_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and transmit fetch.
  always_comb begin
    // Read data fall back to zero between reads, so a stale answer is never taken twice.
    rdData_nxt = 8'h00;
    if (bus.rdStrobe && (bus.addr == WTR_OFS_CTRL)) begin
      rdData_nxt = ctrl_r;
    end else if (bus.rdStrobe && (bus.addr == WTR_OFS_VALUE)) begin
      // The read-back path leaves the held value untouched, so a later value read outside read access still returns it.
      if (accessGate && (ctrl_r.dir == WTR_DIR_READ)) begin
        rdData_nxt = {1'b0, ramAtIndex};
      end else begin
        rdData_nxt = {1'b0, value_r};
      end
    end
    // Out-of-range fetches return zero rather than wrapping onto a real entry.
    txSample_nxt = (txSampleIndex <= WTR_LAST_INDEX) ? ramMem_r[txSampleIndex] : WTR_SAMPLE_RST;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_r <= 8'h00;
      txSample_r <= WTR_SAMPLE_RST;
    end else begin
      rdData_r <= rdData_nxt;
      txSample_r <= txSample_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Internal terms are named in the checks, so that a failure points at the stage that broke.
  AST_STORE: assert property (@(posedge mclk) disable iff (sys_rst)
    ramStore |=> ramMem_r[$past(ctrl_r.index)] == $past(bus.wrData[SAMPLE_W-1:0]))
    else $error("Sample write did not reach the template memory.");

  AST_NO_USER_SHAPE: assert property (@(posedge mclk) disable iff (sys_rst)
    !userShape |=> $stable(ramMem_r))
    else $error("Template memory changed without the user shape selected.");

  AST_ENABLE_GATE: assert property (@(posedge mclk) disable iff (sys_rst)
    (ctrl_r.enable && userShape) |=> active_r)
    else $error("Access not active with enable and user shape set.");

  AST_DIR_READ_NO_STORE: assert property (@(posedge mclk) disable iff (sys_rst)
    (ctrl_r.dir == WTR_DIR_READ) && (ctrl_nxt.dir == WTR_DIR_READ) |=> $stable(ramMem_r))
    else $error("Template memory written in the read direction.");

  AST_CTRL_RESET: assert property (@(posedge mclk)
    sys_rst |=> (ctrl_r == wtr_ctrl_s'(WTR_CTRL_RST)) || sys_rst)
    else $error("Control fields not at their defaults after reset.");

  AST_BAD_INDEX: assert property (@(posedge mclk) disable iff (sys_rst)
    (ctrl_r.index > WTR_LAST_INDEX) && !ctrlWrite |=> $stable(ramMem_r))
    else $error("Out-of-range index changed the template memory.");

  AST_VALUE_HELD: assert property (@(posedge mclk) disable iff (sys_rst)
    !valueWrite |=> $stable(value_r))
    else $error("Sample value changed without a write.");

  AST_READBACK: assert property (@(posedge mclk) disable iff (sys_rst)
    (bus.rdStrobe && (bus.addr == WTR_OFS_VALUE) && accessGate && (ctrl_r.dir == WTR_DIR_READ) && indexValid)
    |=> regRdData == {1'b0, $past(ramAtIndex)})
    else $error("Enabled read did not return the template entry.");

  AST_CTRL_READ: assert property (@(posedge mclk) disable iff (sys_rst)
    (bus.rdStrobe && (bus.addr == WTR_OFS_CTRL)) |=> regRdData == $past(ctrl_r))
    else $error("Control read-back mismatch.");

  AST_ACTIVE_NEEDS_SHAPE: assert property (@(posedge mclk) disable iff (sys_rst)
    !userShape |=> !active_r)
    else $error("Access active although the user shape was not selected.");

  AST_READ_NEEDS_SHAPE: assert property (@(posedge mclk) disable iff (sys_rst)
    (bus.rdStrobe && (bus.addr == WTR_OFS_VALUE) && !userShape) |=> regRdData == {1'b0, $past(value_r)})
    else $error("Template entry returned without the user shape selected.");

  AST_DISABLED_NO_STORE: assert property (@(posedge mclk) disable iff (sys_rst)
    !ctrl_r.enable |=> $stable(ramMem_r))
    else $error("Template memory changed with the access disabled.");

  AST_ACTIVE_DROP: assert property (@(posedge mclk) disable iff (sys_rst)
    !ctrl_r.enable |=> !active_r)
    else $error("Access still active after the enable was cleared.");

  AST_CTRL_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrlWrite |=> ctrl_r == {1'b0, $past(regWrData[6:0])})
    else $error("Control write did not load the control fields.");

  AST_CTRL_HELD: assert property (@(posedge mclk) disable iff (sys_rst)
    !ctrlWrite |=> $stable(ctrl_r))
    else $error("Control fields changed without a control write.");

  AST_CTRL_RESERVED: assert property (@(posedge mclk) disable iff (sys_rst)
    !ctrl_r.reserved)
    else $error("Reserved control bit is set.");

  AST_VALUE_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)
    valueWrite |=> value_r == $past(regWrData[SAMPLE_W-1:0]))
    else $error("Sample write did not load the value register.");

  AST_VALUE_READ: assert property (@(posedge mclk) disable iff (sys_rst)
    (bus.rdStrobe && (bus.addr == WTR_OFS_VALUE) && !(accessGate && (ctrl_r.dir == WTR_DIR_READ)))
    |=> regRdData == {1'b0, $past(value_r)})
    else $error("Value read did not return the held sample value.");

  AST_VALUE_RESET: assert property (@(posedge mclk)
    sys_rst |=> (value_r == WTR_VALUE_RST) || sys_rst)
    else $error("Sample value not at its default after reset.");

  AST_READ_DIR_STORE_OFF: assert property (@(posedge mclk) disable iff (sys_rst)
    (ctrl_r.dir == WTR_DIR_READ) |-> !ramStore)
    else $error("Store requested in the read direction.");

  AST_STORE_NEEDS_VALID_INDEX: assert property (@(posedge mclk) disable iff (sys_rst)
    !indexValid |-> !ramStore)
    else $error("Store requested with an index outside the template.");

  AST_STORE_NEEDS_ACTIVE: assert property (@(posedge mclk) disable iff (sys_rst)
    !accessActive |-> !ramStore)
    else $error("Store requested while the access was not active.");

  AST_STORE_NEEDS_SHAPE: assert property (@(posedge mclk) disable iff (sys_rst)
    !userShape |-> !ramStore)
    else $error("Store requested without the user shape selected.");

  AST_MEM_RESET: assert property (@(posedge mclk)
    sys_rst |=> (ramMem_r == '0) || sys_rst)
    else $error("Template memory not cleared by reset.");

  AST_TX_OUT_OF_RANGE: assert property (@(posedge mclk) disable iff (sys_rst)
    (txSampleIndex > WTR_LAST_INDEX) |=> txSample == WTR_SAMPLE_RST)
    else $error("Out-of-range fetch did not return zero.");

  AST_TX_LAST: assert property (@(posedge mclk) disable iff (sys_rst)
    (txSampleIndex == WTR_LAST_INDEX) |=> txSample == $past(ramMem_r[WTR_LAST_INDEX]))
    else $error("Fetch of the last entry returned the wrong sample.");

  AST_TX_FIRST: assert property (@(posedge mclk) disable iff (sys_rst)
    (txSampleIndex == 5'h00) |=> txSample == $past(ramMem_r[0]))
    else $error("Fetch of the first entry returned the wrong sample.");

  AST_READ_IDLE: assert property (@(posedge mclk) disable iff (sys_rst)
    !bus.rdStrobe |=> regRdData == 8'h00)
    else $error("Read data not zero outside a read answer.");

  AST_UNMAPPED_READ: assert property (@(posedge mclk) disable iff (sys_rst)
    (bus.rdStrobe && (bus.addr != WTR_OFS_CTRL) && (bus.addr != WTR_OFS_VALUE))
    |=> regRdData == 8'h00)
    else $error("Unmapped read returned nonzero data.");

  AST_READ_OUT_OF_RANGE: assert property (@(posedge mclk) disable iff (sys_rst)
    (bus.rdStrobe && (bus.addr == WTR_OFS_VALUE) && accessGate && (ctrl_r.dir == WTR_DIR_READ) && !indexValid)
    |=> regRdData == 8'h00)
    else $error("Read beyond the template returned nonzero data.");

  AST_READ_DATA_ONE_CYCLE: assert property (@(posedge mclk) disable iff (sys_rst)
    !$past(regRdStrobe) |-> regRdData == 8'h00)
    else $error("Read data stood longer than one cycle.");

  AST_RDDATA_BIT7: assert property (@(posedge mclk) disable iff (sys_rst)
    !regRdData[7])
    else $error("Bit 7 of the read data is set.");

  // Each entry may change only through a store aimed at its own index, which catches a decode that spills.
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : gEntryCheck
      AST_ENTRY_ISOLATED: assert property (@(posedge mclk) disable iff (sys_rst)
        !(ramStore && (ctrl_r.index == 5'(gi))) |=> $stable(ramMem_r[gi]))
        else $error("A template entry changed without a store to its index.");
    end
  endgenerate

  COV_STORE: cover property (@(posedge mclk) disable iff (sys_rst) ramStore);
  COV_READBACK: cover property (@(posedge mclk) disable iff (sys_rst)
    bus.rdStrobe && (bus.addr == WTR_OFS_VALUE) && accessGate && (ctrl_r.dir == WTR_DIR_READ));
  COV_LAST_ENTRY: cover property (@(posedge mclk) disable iff (sys_rst)
    ramStore && (ctrl_r.index == WTR_LAST_INDEX));
  COV_HELD_READ: cover property (@(posedge mclk) disable iff (sys_rst)
    bus.rdStrobe && (bus.addr == WTR_OFS_VALUE) && (ctrl_r.dir == WTR_DIR_WRITE));
  COV_BLOCKED_WRITE: cover property (@(posedge mclk) disable iff (sys_rst)
    valueWrite && !ramStore);

endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import wtr_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrStrobe = 1'b0;
  logic regRdStrobe = 1'b0;
  logic [7:0] regRdData;
  logic [3:0] pulseShapeSelect = 4'h0;
  logic [4:0] txSampleIndex = 5'h00;
  logic [6:0] txSample;
  logic accessActive;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #5 mclk = ~mclk;
  wtr_access dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .pulseShapeSelect(pulseShapeSelect), .txSampleIndex(txSampleIndex), .txSample(txSample),
    .accessActive(accessActive));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge mclk);
    regWrStrobe <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge mclk);
    regRdStrobe <= 1'b0;
    #1;
    chk("regRdData", exp, regRdData);
  endtask
  task automatic tx(input logic [4:0] i, input logic [6:0] exp);
    @(posedge mclk);
    txSampleIndex <= i;
    @(posedge mclk);
    #1;
    chk("txSample", {1'b0, exp}, {1'b0, txSample});
  endtask
  task automatic act(input logic exp);
    @(posedge mclk);
    #1;
    chk("accessActive", {7'h00, exp}, {7'h00, accessActive});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(WTR_OFS_CTRL, 8'h00);
    rd(WTR_OFS_VALUE, 8'h00);
    act(1'b0);
    tx(5'h00, 7'h00);
  endtask
  // Without the top select bit nothing may reach the template.
  task automatic t_gated();
    @(posedge mclk);
    pulseShapeSelect <= 4'h7;
    wr(WTR_OFS_CTRL, 8'h45);
    act(1'b0);
    wr(WTR_OFS_VALUE, 8'h33);
    tx(5'h05, 7'h00);
  endtask
  task automatic t_write();
    @(posedge mclk);
    pulseShapeSelect <= 4'h8;
    wr(WTR_OFS_CTRL, 8'h45);
    act(1'b1);
    wr(WTR_OFS_VALUE, 8'h33);
    tx(5'h05, 7'h33);
    wr(WTR_OFS_CTRL, 8'h52);
    act(1'b1);
    wr(WTR_OFS_VALUE, 8'h7F);
    tx(5'h12, 7'h7F);
    tx(5'h05, 7'h33);
  endtask
  task automatic t_readback();
    wr(WTR_OFS_CTRL, 8'h65);
    act(1'b1);
    rd(WTR_OFS_VALUE, 8'h33);
    wr(WTR_OFS_VALUE, 8'h11);
    tx(5'h05, 7'h33);
    wr(WTR_OFS_CTRL, 8'h72);
    act(1'b1);
    rd(WTR_OFS_VALUE, 8'h7F);
    rd(WTR_OFS_CTRL, 8'h72);
  endtask
  task automatic t_hold();
    wr(WTR_OFS_CTRL, 8'h45);
    rd(WTR_OFS_VALUE, 8'h11);
    rd(8'h0A, 8'h00);
    wr(8'h0A, 8'h5A);
    rd(WTR_OFS_VALUE, 8'h11);
    tx(5'h05, 7'h33);
    tx(5'h13, 7'h00);
  endtask
  task automatic t_disable();
    wr(WTR_OFS_CTRL, 8'h05);
    act(1'b0);
    wr(WTR_OFS_VALUE, 8'h22);
    tx(5'h05, 7'h33);
    wr(WTR_OFS_CTRL, 8'h45);
    pulseShapeSelect <= 4'h0;
    act(1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // The whole sequence needs under a hundred cycles; the ceiling leaves wide margin.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_gated();
    t_write();
    t_readback();
    t_hold();
    t_disable();
    summarize();
  end
endmodule
